// [hdl/cbt_bit_timing.sv]
`include "cbt_defs.svh"
`default_nettype none

module cbt_bit_timing #(
    parameter int CFG_W = `CBT_CFG_W
) (
    input  wire logic             sys_clk,
    input  wire logic             srst,
    input  wire logic [CFG_W-1:0] timing_cfg_one,
    input  wire logic [CFG_W-1:0] timing_cfg_two,
    input  wire logic             rx_pin,
    input  wire logic             bus_idle,
    output logic                  bit_value,
    output logic                  sample_strobe,
    output logic                  hard_sync_pulse,
    output logic                  resync_pulse,
    output cbt_pkg::cbt_seg_e     seg_state
);
    import cbt_pkg::*;

    cbt_bt_s    st;
    cbt_bt_s    next_st;
    logic       half_tick;
    logic       tq_tick;
    logic [4:0] prop_len;
    logic [4:0] phase1_len;
    logic [4:0] phase2_len;
    logic [4:0] jump_width;
    logic [4:0] ph1_eff;
    logic [4:0] ph2_eff;
    logic [4:0] pos;
    logic [4:0] rem;
    logic       triple_sample_sel;
    logic       early_start;
    logic       sample_val;

    // field value n encodes n+1 quanta
    function automatic logic [4:0] seg_len(input logic [2:0] f);
        seg_len = {2'b00, f} + 5'h01;
    endfunction

    function automatic logic majority(input logic a, input logic b, input logic c);
        majority = (a & b) | (a & c) | (b & c);
    endfunction

    cbt_quanta #(
        .PRESC_W(`CBT_PRESC_W)
    ) u_quanta (
        .sys_clk         (sys_clk),
        .srst            (srst),
        .quantum_prescale(timing_cfg_one[`CBT_PRESC_LSB +: `CBT_PRESC_W]),
        .half_tick       (half_tick),
        .tq_tick         (tq_tick)
    );

    always_comb begin
        prop_len          = seg_len(timing_cfg_two[`CBT_PROP_LSB +: `CBT_SEG_W]);
        phase1_len        = seg_len(timing_cfg_two[`CBT_PH1_LSB +: `CBT_SEG_W]);
        triple_sample_sel = timing_cfg_two[`CBT_TRIPLE_BIT];
        jump_width        = seg_len({1'b0, timing_cfg_one[`CBT_SJW_LSB +: `CBT_SJW_W]});
        if (timing_cfg_two[`CBT_PH2_PROG_BIT]) begin
            phase2_len = seg_len(timing_cfg_two[`CBT_PH2_LSB +: `CBT_SEG_W]);
        end else begin
            phase2_len = (phase1_len > `CBT_IPT_TQ) ? phase1_len : `CBT_IPT_TQ;
        end
        pos         = '0;
        rem         = '0;
        early_start = 1'b0;
        ph1_eff     = phase1_len;
        ph2_eff     = phase2_len;
        // hist holds the two half-quantum samples before the sample point
        sample_val  = triple_sample_sel ? majority(st.hist[1], st.hist[0], st.rx_sync) : st.rx_sync;

        next_st               = st;
        next_st.sample_strobe = 1'b0;
        next_st.hard_sync     = 1'b0;
        next_st.resync        = 1'b0;
        next_st.rx_meta       = rx_pin;
        next_st.rx_sync       = st.rx_meta;
        next_st.rx_prev       = st.rx_sync;
        if (half_tick) begin
            next_st.hist = {st.hist[0], st.rx_sync};
        end
        // a fall in the consuming cycle is kept for the next quantum
        if (tq_tick) begin
            next_st.edge_pend = st.rx_prev & ~st.rx_sync;
        end else if (st.rx_prev && !st.rx_sync) begin
            next_st.edge_pend = 1'b1;
        end

        if (tq_tick && st.edge_pend && bus_idle) begin
            // edge quantum becomes the sync segment of a fresh bit
            next_st.seg       = SEG_PROP;
            next_st.cnt       = '0;
            next_st.ext       = '0;
            next_st.cut       = '0;
            next_st.hs_bit    = 1'b1;
            next_st.rs_bit    = 1'b0;
            next_st.hard_sync = 1'b1;
        end else if (tq_tick) begin
            if (st.edge_pend && !st.hs_bit && !st.rs_bit) begin
                case (st.seg)
                    SEG_PROP, SEG_PH1: begin
                        pos = (st.seg == SEG_PROP) ? {1'b0, st.cnt} + 5'h01
                                                   : prop_len + {1'b0, st.cnt} + 5'h01;
                        next_st.ext    = (pos > jump_width) ? jump_width[2:0] : pos[2:0];
                        next_st.rs_bit = 1'b1;
                        next_st.resync = 1'b1;
                    end
                    SEG_PH2: begin
                        rem = phase2_len - {2'b00, st.cut} - {1'b0, st.cnt};
                        if (rem <= jump_width) begin
                            early_start = 1'b1;
                        end else begin
                            next_st.cut = jump_width[2:0];
                        end
                        next_st.rs_bit = 1'b1;
                        next_st.resync = 1'b1;
                    end
                    default: begin
                        // edge inside the sync segment needs no correction
                        next_st.rs_bit = st.rs_bit;
                    end
                endcase
            end
            ph1_eff = phase1_len + {2'b00, next_st.ext};
            ph2_eff = phase2_len - {2'b00, next_st.cut};
            case (st.seg)
                SEG_SYNC: begin
                    next_st.seg = SEG_PROP;
                    next_st.cnt = '0;
                end
                SEG_PROP: begin
                    if ({1'b0, st.cnt} + 5'h01 >= prop_len) begin
                        next_st.seg = SEG_PH1;
                        next_st.cnt = '0;
                    end else begin
                        next_st.cnt = st.cnt + 4'h1;
                    end
                end
                SEG_PH1: begin
                    if ({1'b0, st.cnt} + 5'h01 >= ph1_eff) begin
                        next_st.seg           = SEG_PH2;
                        next_st.cnt           = '0;
                        next_st.bit_value     = sample_val;
                        next_st.sample_strobe = 1'b1;
                    end else begin
                        next_st.cnt = st.cnt + 4'h1;
                    end
                end
                SEG_PH2: begin
                    if (early_start) begin
                        // edge quantum taken as the next bit's sync segment
                        next_st.seg    = SEG_PROP;
                        next_st.cnt    = '0;
                        next_st.ext    = '0;
                        next_st.cut    = '0;
                        next_st.hs_bit = 1'b0;
                        next_st.rs_bit = 1'b0;
                    end else if ({1'b0, st.cnt} + 5'h01 >= ph2_eff) begin
                        next_st.seg    = SEG_SYNC;
                        next_st.cnt    = '0;
                        next_st.ext    = '0;
                        next_st.cut    = '0;
                        next_st.hs_bit = 1'b0;
                        next_st.rs_bit = 1'b0;
                    end else begin
                        next_st.cnt = st.cnt + 4'h1;
                    end
                end
                default: begin
                    next_st.seg = SEG_SYNC;
                    next_st.cnt = '0;
                end
            endcase
        end else begin
            ph1_eff = phase1_len;
            ph2_eff = phase2_len;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st           <= '0;
            st.rx_meta   <= `CBT_RX_RECESSIVE;
            st.rx_sync   <= `CBT_RX_RECESSIVE;
            st.rx_prev   <= `CBT_RX_RECESSIVE;
            st.bit_value <= `CBT_RX_RECESSIVE;
        end else begin
            st <= next_st;
        end
    end

    assign bit_value       = st.bit_value;
    assign sample_strobe   = st.sample_strobe;
    assign hard_sync_pulse = st.hard_sync;
    assign resync_pulse    = st.resync;
    assign seg_state       = st.seg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_prop_length: assert property ($past(st.seg) == SEG_PROP && st.seg == SEG_PH1
        |-> {1'b0, $past(st.cnt)} + 5'h01 == $past(prop_len))
        else $error("propagation segment length wrong");
    a_sample_point: assert property (st.sample_strobe |-> $past(st.seg) == SEG_PH1 && st.seg == SEG_PH2)
        else $error("sample not at end of phase 1");
    a_ph2_auto: assert property ($past(st.seg) == SEG_PH2 && st.seg == SEG_SYNC
        && !$past(timing_cfg_two[`CBT_PH2_PROG_BIT]) && $past(st.cut) == 3'h0
        |-> {1'b0, $past(st.cnt)} + 5'h01 == (($past(phase1_len) > 5'h02) ? $past(phase1_len) : 5'h02))
        else $error("automatic phase 2 length wrong");
    a_ph2_prog: assert property ($past(st.seg) == SEG_PH2 && st.seg == SEG_SYNC
        && $past(timing_cfg_two[`CBT_PH2_PROG_BIT]) && $past(st.cut) == 3'h0
        |-> $past(st.cnt) == {1'b0, $past(timing_cfg_two[`CBT_PH2_LSB +: `CBT_SEG_W])})
        else $error("programmed phase 2 length wrong");
    a_triple_vote: assert property (st.sample_strobe && $past(triple_sample_sel)
        |-> st.bit_value == majority($past(st.hist[1]), $past(st.hist[0]), $past(st.rx_sync)))
        else $error("majority vote wrong");
    a_single_sample: assert property (st.sample_strobe && !$past(triple_sample_sel)
        |-> st.bit_value == $past(st.rx_sync))
        else $error("single sample wrong");
    a_hard_idle: assert property (st.hard_sync |-> $past(bus_idle) && $past(st.edge_pend))
        else $error("hard sync without idle edge");
    a_hard_restart: assert property (st.hard_sync |-> st.seg == SEG_PROP && st.cnt == 4'h0 ##1 st.hs_bit)
        else $error("hard sync did not restart the bit");
    a_no_double: assert property (st.hs_bit |-> !st.resync)
        else $error("resync in a hard synced bit");
    a_resync_cause: assert property (st.resync |-> $past(st.edge_pend) && $past(tq_tick))
        else $error("resync without an edge");
    a_jump_bound: assert property ({2'b00, st.ext} <= jump_width && {2'b00, st.cut} <= jump_width)
        else $error("phase adjust beyond jump width");
    a_seg_order: assert property (st.seg == SEG_PH1 && $past(st.seg) != SEG_PH1 |-> $past(st.seg) == SEG_PROP)
        else $error("phase 1 not entered from propagation");

    c_hard_sync: cover property (st.hard_sync);
    c_resync_long: cover property (st.resync && st.ext != 3'h0);
    c_resync_short: cover property (st.resync && st.cut != 3'h0);
    c_triple: cover property (st.sample_strobe && triple_sample_sel);

endmodule

`default_nettype wire

// [include/cbt_defs.svh]
`ifndef CBT_DEFS_SVH
`define CBT_DEFS_SVH

// width of each timing configuration word
`define CBT_CFG_W 16

// timing_cfg_one fields
`define CBT_PRESC_LSB 0
`define CBT_PRESC_W 6
`define CBT_SJW_LSB 6
`define CBT_SJW_W 2

// timing_cfg_two fields
`define CBT_PROP_LSB 0
`define CBT_PH1_LSB 3
`define CBT_TRIPLE_BIT 6
`define CBT_PH2_PROG_BIT 7
`define CBT_PH2_LSB 8
`define CBT_SEG_W 3

// information processing time in quanta
`define CBT_IPT_TQ 5'h02

// reset level of the bus input path
`define CBT_RX_RECESSIVE 1'b1

`endif

// [include/cbt_pkg.sv]
`default_nettype none

package cbt_pkg;

    typedef enum logic [1:0] {
        SEG_SYNC,
        SEG_PROP,
        SEG_PH1,
        SEG_PH2
    } cbt_seg_e;

    typedef struct packed {
        logic       rx_meta;
        logic       rx_sync;
        logic       rx_prev;
        logic       edge_pend;
        logic [1:0] hist;
        cbt_seg_e   seg;
        logic [3:0] cnt;
        logic [2:0] ext;
        logic [2:0] cut;
        logic       hs_bit;
        logic       rs_bit;
        logic       bit_value;
        logic       sample_strobe;
        logic       hard_sync;
        logic       resync;
    } cbt_bt_s;

    typedef struct packed {
        logic [5:0] cnt;
        logic       phase;
        logic       half_tick;
        logic       tq_tick;
    } cbt_q_s;

endpackage

`default_nettype wire

// [hdl/cbt_quanta.sv]
`include "cbt_defs.svh"
`default_nettype none

module cbt_quanta #(
    parameter int PRESC_W = `CBT_PRESC_W
) (
    input  wire logic               sys_clk,
    input  wire logic               srst,
    input  wire logic [PRESC_W-1:0] quantum_prescale,
    output logic                    half_tick,
    output logic                    tq_tick
);
    import cbt_pkg::*;

    cbt_q_s q;
    cbt_q_s next_q;

    // half quantum is prescale+1 clocks; the phase bit is the fixed divide-by-two
    always_comb begin
        next_q           = q;
        next_q.half_tick = 1'b0;
        next_q.tq_tick   = 1'b0;
        if (q.cnt >= quantum_prescale) begin
            next_q.cnt       = '0;
            next_q.half_tick = 1'b1;
            next_q.tq_tick   = q.phase;
            next_q.phase     = ~q.phase;
        end else begin
            next_q.cnt = q.cnt + 6'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign half_tick = q.half_tick;
    assign tq_tick   = q.tq_tick;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    // a prescale lowered mid-count ends the half quantum at once, so the count may exceed it
    a_half_spacing: assert property (q.half_tick |-> $past(q.cnt) >= $past(quantum_prescale))
        else $error("half quantum tick before the prescale count");
    a_tq_every_two: assert property (q.tq_tick |-> q.half_tick && !q.phase)
        else $error("quantum tick not on every second half tick");

endmodule

`default_nettype wire

// [bench/cbt_far_node.sv]
`default_nettype none

module cbt_far_node (
    input  wire logic sys_clk,
    output var logic  rx_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // recessive while idle, as the bus pull-up would leave it
    initial rx_pin = 1'b1;

    // another node moves the bus level some clocks late or early in the bit
    task automatic drive(input logic v, input int dly);
        repeat (dly) @(negedge sys_clk);
        rx_pin = v;
    endtask
endmodule

`default_nettype wire

// [bench/can_bit_timing_sync_tb_top.sv]
`default_nettype none

module can_bit_timing_sync_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cbt_pkg::*;

    logic        sys_clk        = 1'b0;
    logic        srst           = 1'b1;
    logic [15:0] timing_cfg_one = 16'h0000;
    logic [15:0] timing_cfg_two = 16'h0000;
    logic        bus_idle       = 1'b1;
    wire logic   rx_pin;
    logic        bit_value;
    logic        sample_strobe;
    logic        hard_sync_pulse;
    logic        resync_pulse;
    cbt_seg_e    seg_state;
    int          mismatches     = 0;
    int          checked        = 0;
    int          cycles         = 0;
    int          seed           = 32'h80FE;
    int          run            = 0;
    int          rs_cnt         = 0;
    int          hs_cnt         = 0;
    int          q_seg[$];
    int          q_len[$];
    cbt_seg_e    last           = SEG_SYNC;

    always #12.5 sys_clk = ~sys_clk;

    cbt_bit_timing i_dut (
        .sys_clk         (sys_clk),
        .srst            (srst),
        .timing_cfg_one  (timing_cfg_one),
        .timing_cfg_two  (timing_cfg_two),
        .rx_pin          (rx_pin),
        .bus_idle        (bus_idle),
        .bit_value       (bit_value),
        .sample_strobe   (sample_strobe),
        .hard_sync_pulse (hard_sync_pulse),
        .resync_pulse    (resync_pulse),
        .seg_state       (seg_state)
    );

    cbt_far_node i_node (
        .sys_clk (sys_clk),
        .rx_pin  (rx_pin)
    );

    task automatic results();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // model of the bit: run lengths of each segment in clocks, queued
    always @(negedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            results();
        end
        rs_cnt += int'(resync_pulse === 1'b1);
        hs_cnt += int'(hard_sync_pulse === 1'b1);
        if (seg_state !== last) begin
            q_seg.push_back(int'(last));
            q_len.push_back(run);
            last = seg_state;
            run = 0;
        end
        run++;
    end

    // cleared on the rising edge so it never races the monitor
    task automatic clr();
        @(posedge sys_clk);
        q_seg.delete();
        q_len.delete();
        rs_cnt = 0;
        hs_cnt = 0;
        @(negedge sys_clk);
    endtask

    task automatic wait_seg(input cbt_seg_e s);
        while (seg_state !== s) @(negedge sys_clk);
    endtask

    task automatic skip_to(input cbt_seg_e s);
        int got;
        got = -1;
        while (got != int'(s)) begin
            while (q_len.size() == 0) @(negedge sys_clk);
            got = q_seg.pop_front();
            void'(q_len.pop_front());
        end
    endtask

    task automatic nxt(input cbt_seg_e s, input int exp);
        while (q_len.size() == 0) @(negedge sys_clk);
        chk("segment", 32'(s), 32'(q_seg.pop_front()));
        chk("segment clocks", 32'(exp), 32'(q_len.pop_front()));
    endtask

    task automatic set_cfg(input int pr, sj, p, a, tr, pg, b);
        timing_cfg_one = {8'h00, 2'(sj), 6'(pr)};
        timing_cfg_two = {5'h00, 3'(b), 1'(pg), 1'(tr), 3'(a), 3'(p)};
    endtask

    initial begin
        int pr, sj, p, a, tr, pg, b, tq, len;
        repeat (2) @(negedge sys_clk);
        chk("reset segment", 32'(SEG_SYNC), 32'(seg_state));
        chk("reset bit", 32'h1, 32'(bit_value));
        chk("reset pulses", 32'h0, {29'h0, sample_strobe, hard_sync_pulse, resync_pulse});
        repeat (10) @(negedge sys_clk);
        srst = 1'b0;
        // quiet bus, random lengths and prescale
        for (int i = 0; i < 8; i++) begin
            pr = {$random(seed)} % 4;
            sj = {$random(seed)} % 2;
            p = 3 + {$random(seed)} % 5;
            a = 2 + {$random(seed)} % 6;
            b = 2 + {$random(seed)} % 6;
            if (b > p + a + 1) b = p + a + 1;
            tr = {$random(seed)} % 2;
            pg = {$random(seed)} % 2;
            set_cfg(pr, sj, p, a, tr, pg, b);
            tq = 2 * (pr + 1);
            clr();
            skip_to(SEG_PH2);
            nxt(SEG_SYNC, tq);
            nxt(SEG_PROP, (p + 1) * tq);
            nxt(SEG_PH1, (a + 1) * tq);
            nxt(SEG_PH2, (pg != 0 ? b + 1 : a + 1) * tq);
        end
        // late edge in a long phase 1, every jump width
        bus_idle = 1'b0;
        for (int s = 0; s < 4; s++) begin
            set_cfg(1, s, 0, 7, 0, 1, 7);
            wait_seg(SEG_PH2);
            wait_seg(SEG_SYNC);
            wait_seg(SEG_PH1);
            clr();
            i_node.drive(1'b0, 12);
            nxt(SEG_PH1, (9 + s) * 4);
            chk("resync count", 32'h1, 32'(rs_cnt));
            chk("hard sync count", 32'h0, 32'(hs_cnt));
            chk("bit", 32'h0, 32'(bit_value));
            i_node.drive(1'b1, 4);
            nxt(SEG_PH2, 32);
            chk("resync count", 32'h1, 32'(rs_cnt));
        end
        // frame start on an idle bus, then a second edge in the same bit
        bus_idle = 1'b1;
        set_cfg(1, 0, 3, 3, 0, 1, 3);
        wait_seg(SEG_SYNC);
        wait_seg(SEG_PH1);
        clr();
        i_node.drive(1'b0, 5);
        skip_to(SEG_PH1);
        nxt(SEG_PROP, 16);
        chk("hard sync count", 32'h1, 32'(hs_cnt));
        bus_idle = 1'b0;
        i_node.drive(1'b1, 2);
        i_node.drive(1'b0, 2);
        nxt(SEG_PH1, 16);
        chk("resync count", 32'h0, 32'(rs_cnt));
        nxt(SEG_PH2, 16);
        // dominant bit released just before the sample point
        for (int t = 0; t < 2; t++) begin
            set_cfg(7, 0, 3, 3, t, 1, 3);
            wait_seg(SEG_PH2);
            clr();
            // fall early in phase 2 (t=1 only; the bus is already dominant at t=0) only shortens that bit, the next phase 1 stays plain
            i_node.drive(1'b0, 1);
            wait_seg(SEG_SYNC);
            wait_seg(SEG_PH1);
            i_node.drive(1'b1, 58);
            while (sample_strobe !== 1'b1) @(negedge sys_clk);
            chk("strobe segment", 32'(SEG_PH2), 32'(seg_state));
            chk("voted bit", 32'(1 - t), 32'(bit_value));
            chk("resync count", 32'(t), 32'(rs_cnt));
        end
        // edge in the last phase 2 quantum starts the next bit at once
        clr();
        i_node.drive(1'b0, 50);
        nxt(SEG_PH2, 64);
        nxt(SEG_PROP, 64);
        chk("resync count", 32'h1, 32'(rs_cnt));
        results();
    end
endmodule

`default_nettype wire
